// *** hdl/bet_top.sv ***
/*
 Bit error rate tester: pattern generator, checker, counters and APB registers.
 Assumes framer slot timing and data on core_clk, and a zero-wait APB master.
*/
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module bet_top #(
    parameter int BCNT_W = 32,
    parameter int ECNT_W = 24,
    parameter int DALY_LEN = 64,
    parameter logic [63:0] DALY_PAT = 64'h0000_0000_0000_0001
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire bet_pkg::bet_slot_t frm_slot,
    input wire logic t1_mode,
    input wire logic net_tx_in,
    input wire logic bp_tx_in,
    input wire logic net_rx_in,
    input wire logic bp_rx_in,
    output logic net_tx_out,
    output logic bp_tx_out,
    output logic event_alert
);
    import bet_pkg::*;

    // Software visible state.
    logic [31:0] ctrl_reg, pat_reg, txsel_reg, rxsel_reg;
    logic [7:0] awc_reg;
    logic [3:0] ifc_reg, info_reg, sr9_reg;
    logic lc_seen_reg;
    // Counters and checker state.
    logic [BCNT_W-1:0] bcnt_reg;
    logic [ECNT_W-1:0] ecnt_reg;
    bet_sync_t sync_reg, sync_next;
    logic [7:0] good_reg;
    logic [5:0] win_reg;
    logic [3:0] werr_reg;
    bet_gen_t txg_reg, rxg_reg;
    logic net_tx_reg, bp_tx_reg;
    // Decoded control fields.
    logic [2:0] mode;
    logic [4:0] pat_len;
    logic enabled, dir_bp, wr_done, rd_done, addr_ok, lc_edge, tx_use;
    logic rx_use, rx_bit, gen_tx, exp_bit, rx_err, cnt_tick, is_prbs;
    logic [3:0] ev_set, msk;
    logic [31:0] rdata_next;
    bet_gen_t seed;

    assign mode = ctrl_reg[CTL_MODE+:3];
    assign pat_len = ctrl_reg[CTL_LEN+:5];
    assign enabled = ctrl_reg[CTL_EN] & ifc_reg[IFC_ACT];
    assign dir_bp = ifc_reg[IFC_DIR];
    assign is_prbs = (mode == PM_PRBS7) | (mode == PM_PRBS11) | (mode == PM_PRBS15)
        | (mode == PM_QRSS);
    assign seed = '{lfsr: pat_reg[19:0], pos: 6'h00, words: 8'h00, sel: 1'b0};

    // Feedback taps of the four PRBS polynomials.
    function automatic logic prbs_fb(bet_gen_t g);
        logic fb;
        case (mode)
            PM_PRBS7: fb = g.lfsr[6] ^ g.lfsr[5];
            PM_PRBS11: fb = g.lfsr[10] ^ g.lfsr[8];
            PM_PRBS15: fb = g.lfsr[14] ^ g.lfsr[13];
            default: fb = g.lfsr[19] ^ g.lfsr[16];
        endcase
        return fb;
    endfunction

    // Pattern bit at the present generator position.
    function automatic logic gen_bit(bet_gen_t g);
        logic b;
        case (mode)
            PM_PRBS7, PM_PRBS11, PM_PRBS15: b = prbs_fb(g);
            // QRSS forces a one after fourteen zeros.
            PM_QRSS: b = prbs_fb(g) | ~|g.lfsr[13:0];
            PM_REPEAT: b = pat_reg[g.pos[4:0]];
            PM_ALTWORD: b = pat_reg[{g.sel, g.pos[3:0]}];
            default: b = DALY_PAT[g.pos];
        endcase
        return b;
    endfunction

    // Advance a generator by one bit; the checker feeds received bits into its PRBS.
    function automatic bet_gen_t gen_step(bet_gen_t g, logic use_in, logic in_bit);
        bet_gen_t n;
        n = g;
        case (mode)
            PM_PRBS7, PM_PRBS11, PM_PRBS15, PM_QRSS: begin
                n.lfsr = {g.lfsr[18:0], use_in ? in_bit : prbs_fb(g)};
            end
            PM_REPEAT: begin
                n.pos = (g.pos[4:0] == pat_len) ? 6'h00 : g.pos + 6'h01;
            end
            PM_ALTWORD: begin
                n.pos = {2'b00, g.pos[3:0] + 4'h1};
                if (g.pos[3:0] == 4'hF) begin
                    n.words = g.words + 8'h01;
                    // A count of zero gives 256 words through wrap.
                    if (g.words == awc_reg - 8'h01) begin
                        n.words = 8'h00;
                        n.sel = ~g.sel;
                    end
                end
            end
            default: begin
                n.pos = (g.pos == 6'(DALY_LEN - 1)) ? 6'h00 : g.pos + 6'h01;
            end
        endcase
        return n;
    endfunction

    // Slot selection for each direction, framing bit only in T1.
    always_comb begin
        tx_use = 1'b0;
        rx_use = 1'b0;
        if (enabled && frm_slot.valid) begin
            if (frm_slot.fbit) begin
                tx_use = t1_mode & ifc_reg[IFC_TX_FRAMING_BIT_USE];
                rx_use = t1_mode & ifc_reg[IFC_RX_FRAMING_BIT_USE];
            end else begin
                tx_use = txsel_reg[frm_slot.slot];
                rx_use = rxsel_reg[frm_slot.slot];
            end
        end
    end

    assign rx_bit = dir_bp ? bp_rx_in : net_rx_in;
    assign gen_tx = gen_bit(txg_reg);
    assign exp_bit = gen_bit(rxg_reg);
    assign rx_err = rx_use & (rx_bit != exp_bit);
    assign cnt_tick = rx_use & (sync_reg == SY_LOCK);
    assign lc_edge = ctrl_reg[CTL_LC] ^ lc_seen_reg;

    // Transmit generator steps only in its own slots.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            txg_reg <= '0;
        end else if (ce) begin
            if (!enabled) begin
                txg_reg <= seed;
            end else if (tx_use) begin
                txg_reg <= gen_step(txg_reg, 1'b0, 1'b0);
            end
        end
    end

    // Registered data outputs; the tester replaces only its slots.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            net_tx_reg <= 1'b0;
            bp_tx_reg <= 1'b0;
        end else if (ce) begin
            net_tx_reg <= (tx_use && !dir_bp) ? gen_tx : net_tx_in;
            bp_tx_reg <= (tx_use && dir_bp) ? gen_tx : bp_tx_in;
        end
    end

    // Receive reference; outside PRBS modes a miss while hunting holds it one bit to slip.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rxg_reg <= '0;
        end else if (ce) begin
            if (!enabled) begin
                rxg_reg <= seed;
            end else if (rx_use) begin
                if (is_prbs || sync_reg == SY_LOCK || !rx_err) begin
                    rxg_reg <= gen_step(rxg_reg, is_prbs, rx_bit);
                end
            end
        end
    end

    // Synchroniser: a clean run locks, an error burst in a window unlocks.
    always_comb begin
        sync_next = sync_reg;
        case (sync_reg)
            SY_HUNT: begin
                if (rx_use && !rx_err && good_reg == SYNC_GOOD - 8'h01) begin
                    sync_next = SY_LOCK;
                end
            end
            SY_LOCK: begin
                if (rx_err && werr_reg == LOSS_ERRS - 4'h1) begin
                    sync_next = SY_HUNT;
                end
            end
            default: sync_next = SY_HUNT;
        endcase
        if (!enabled) begin
            sync_next = SY_HUNT;
        end
    end

    // State register and the run and window counters behind it.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sync_reg <= SY_HUNT;
            good_reg <= 8'h00;
            win_reg <= 6'h00;
            werr_reg <= 4'h0;
        end else if (ce) begin
            sync_reg <= sync_next;
            if (sync_next != sync_reg || !enabled) begin
                good_reg <= 8'h00;
                win_reg <= 6'h00;
                werr_reg <= 4'h0;
            end else if (rx_use) begin
                good_reg <= rx_err ? 8'h00 : good_reg + 8'h01;
                win_reg <= win_reg + 6'h01;
                // The error tally restarts each 64-bit window.
                if (win_reg == 6'h3F) begin
                    werr_reg <= 4'h0;
                end else if (rx_err) begin
                    werr_reg <= werr_reg + 4'h1;
                end
            end
        end
    end

    // Saturating counters, cleared by any change of the load bit.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            bcnt_reg <= '0;
            ecnt_reg <= '0;
            lc_seen_reg <= 1'b0;
        end else if (ce) begin
            lc_seen_reg <= ctrl_reg[CTL_LC];
            if (lc_edge) begin
                bcnt_reg <= '0;
                ecnt_reg <= '0;
            end else if (cnt_tick) begin
                if (!(&bcnt_reg)) begin
                    bcnt_reg <= bcnt_reg + 1'b1;
                end
                if (rx_err && !(&ecnt_reg)) begin
                    ecnt_reg <= ecnt_reg + 1'b1;
                end
            end
        end
    end

    // Events; an overflow fires on the step into the full value.
    always_comb begin
        ev_set = 4'h0;
        ev_set[EV_SYNC] = sync_next != sync_reg;
        ev_set[EV_ERR] = cnt_tick & rx_err;
        ev_set[EV_BOVF] = cnt_tick & ~lc_edge & (bcnt_reg == {{(BCNT_W-1){1'b1}}, 1'b0});
        ev_set[EV_EOVF] = cnt_tick & rx_err & ~lc_edge
            & (ecnt_reg == {{(ECNT_W-1){1'b1}}, 1'b0});
    end

    // APB strobes; the slave never inserts wait states beyond ce.
    assign wr_done = psel & penable & pwrite & ce;
    assign rd_done = psel & penable & ~pwrite & ce;
    assign pready = ce;
    assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= ADDR_SR9);
    assign pslverr = psel & penable & ~addr_ok;

    // Latched flags clear on read; a new event in that cycle wins.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            info_reg <= 4'h0;
            sr9_reg <= 4'h0;
        end else if (ce) begin
            if (rd_done && paddr == ADDR_INFO) begin
                info_reg <= ev_set;
            end else begin
                info_reg <= info_reg | ev_set;
            end
            if (rd_done && paddr == ADDR_SR9) begin
                sr9_reg <= ev_set;
            end else begin
                sr9_reg <= sr9_reg | ev_set;
            end
        end
    end

    // Alert reflects status nine gated by the mask bits.
    assign msk = {ctrl_reg[CTL_MSK_OVF], ctrl_reg[CTL_MSK_OVF:CTL_MSK_SYNC]};
    assign event_alert = |(sr9_reg & msk);

    // Register writes; the pattern word must be loaded before enabling.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= CTRL_RST;
            pat_reg <= PAT_RST;
            awc_reg <= AWC_RST;
            ifc_reg <= IFC_RST;
            txsel_reg <= 32'h0000_0000;
            rxsel_reg <= 32'h0000_0000;
        end else if (wr_done) begin
            case (paddr)
                ADDR_CTRL: ctrl_reg <= {19'h0, pwdata[12:0]};
                ADDR_PAT: pat_reg <= pwdata;
                ADDR_AWC: awc_reg <= pwdata[7:0];
                ADDR_IFC: ifc_reg <= pwdata[3:0];
                ADDR_TXSEL: txsel_reg <= pwdata;
                ADDR_RXSEL: rxsel_reg <= pwdata;
                default: ;
            endcase
        end
    end

    // Read data is captured in the setup phase and held for access.
    always_comb begin
        case (paddr)
            ADDR_CTRL: rdata_next = ctrl_reg;
            ADDR_PAT: rdata_next = pat_reg;
            ADDR_AWC: rdata_next = {24'h0, awc_reg};
            ADDR_IFC: rdata_next = {28'h0, ifc_reg};
            ADDR_TXSEL: rdata_next = txsel_reg;
            ADDR_RXSEL: rdata_next = rxsel_reg;
            ADDR_BCNT: rdata_next = 32'(bcnt_reg);
            ADDR_ECNT: rdata_next = 32'(ecnt_reg);
            ADDR_INFO: rdata_next = {27'h0, info_reg, sync_reg == SY_LOCK};
            ADDR_SR9: rdata_next = {28'h0, sr9_reg};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (ce && psel && !penable) begin
            prdata <= rdata_next;
        end
    end

    assign net_tx_out = net_tx_reg;
    assign bp_tx_out = bp_tx_reg;

    // Checks on the design's own behaviour.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    chk_bcnt_step: assert property (ce && cnt_tick && !lc_edge && !(&bcnt_reg)
        |=> bcnt_reg == $past(bcnt_reg) + 1'b1) else $error("bit count did not step");
    chk_bcnt_hold: assert property (ce && !cnt_tick && !lc_edge
        |=> $stable(bcnt_reg)) else $error("bit count moved out of sync");
    chk_ecnt_step: assert property (ce && cnt_tick && rx_err && !lc_edge && !(&ecnt_reg)
        |=> ecnt_reg == $past(ecnt_reg) + 1'b1) else $error("error count did not step");
    chk_lc_clear: assert property (ce && lc_edge
        |=> bcnt_reg == '0 && ecnt_reg == '0) else $error("counters not cleared");
    chk_bcnt_sat: assert property (ce && (&bcnt_reg) && !lc_edge
        |=> (&bcnt_reg)) else $error("bit count wrapped");
    chk_ecnt_sat: assert property (ce && (&ecnt_reg) && !lc_edge
        |=> (&ecnt_reg)) else $error("error count wrapped");
    chk_bovf_flag: assert property (ce && ev_set[EV_BOVF]
        |=> info_reg[EV_BOVF] && sr9_reg[EV_BOVF] && (&bcnt_reg)) else $error("overflow lost");
    chk_sync_event: assert property (ce && sync_next != sync_reg
        |=> info_reg[EV_SYNC] && sr9_reg[EV_SYNC]) else $error("sync change not latched");
    chk_alert_mask: assert property (sr9_reg[EV_ERR] && ctrl_reg[CTL_MSK_ERR]
        |-> event_alert) else $error("unmasked error did not alert");
    chk_tx_pass: assert property (ce && (!tx_use || dir_bp)
        |=> net_tx_out == $past(net_tx_in)) else $error("network transmit not passed");

    cov_lock: cover property (sync_reg == SY_HUNT ##1 sync_reg == SY_LOCK);
    cov_bovf: cover property (ev_set[EV_BOVF]);
    cov_alt_switch: cover property (mode == PM_ALTWORD && $changed(txg_reg.sel));

endmodule

// *** hdl/bet_pkg.sv ***
/*
 Constants, types and register layout shared by the bit error rate tester.
 Assumes a 32-bit APB master and a framer that strobes one bit per slot time.
*/
package bet_pkg;

    // Register byte addresses on the APB side.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PAT = 8'h04;
    localparam logic [7:0] ADDR_AWC = 8'h08;
    localparam logic [7:0] ADDR_IFC = 8'h0C;
    localparam logic [7:0] ADDR_TXSEL = 8'h10;
    localparam logic [7:0] ADDR_RXSEL = 8'h14;
    localparam logic [7:0] ADDR_BCNT = 8'h18;
    localparam logic [7:0] ADDR_ECNT = 8'h1C;
    localparam logic [7:0] ADDR_INFO = 8'h20;
    localparam logic [7:0] ADDR_SR9 = 8'h24;

    // Field positions of tester_control_one.
    localparam int CTL_EN = 0;
    localparam int CTL_MODE = 1;
    localparam int CTL_LC = 4;
    localparam int CTL_MSK_SYNC = 5;
    localparam int CTL_MSK_ERR = 6;
    localparam int CTL_MSK_OVF = 7;
    localparam int CTL_LEN = 8;

    // Field positions of tester_interface_control.
    localparam int IFC_ACT = 0;
    localparam int IFC_DIR = 1;
    localparam int IFC_RX_FRAMING_BIT_USE = 2;
    localparam int IFC_TX_FRAMING_BIT_USE = 3;

    // Event flag positions, shared by event info and status nine.
    localparam int EV_SYNC = 0;
    localparam int EV_ERR = 1;
    localparam int EV_BOVF = 2;
    localparam int EV_EOVF = 3;

    // Reset values.
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] PAT_RST = 32'hFFFF_FFFF;
    localparam logic [7:0] AWC_RST = 8'h01;
    localparam logic [3:0] IFC_RST = 4'h0;

    // Synchroniser thresholds in received bits.
    localparam logic [7:0] SYNC_GOOD = 8'h20;
    localparam logic [3:0] LOSS_ERRS = 4'h6;

    // Pattern modes held in the control mode field.
    typedef enum logic [2:0] {
        PM_PRBS7 = 3'h0,
        PM_PRBS11 = 3'h1,
        PM_PRBS15 = 3'h2,
        PM_QRSS = 3'h3,
        PM_REPEAT = 3'h4,
        PM_ALTWORD = 3'h5,
        PM_DALY = 3'h6
    } bet_mode_t;

    // Synchroniser states, one-hot.
    typedef enum logic [1:0] {
        SY_HUNT = 2'b01,
        SY_LOCK = 2'b10
    } bet_sync_t;

    // Slot timing from the framer.
    typedef struct packed {
        logic valid;
        logic fbit;
        logic [4:0] slot;
    } bet_slot_t;

    // Pattern generator state, used by both transmit and receive.
    typedef struct packed {
        logic [19:0] lfsr;
        logic [5:0] pos;
        logic [7:0] words;
        logic sel;
    } bet_gen_t;

endpackage

// *** verif/bet_framer_model.sv ***
/*
 Behavioural framer: slot strobes, pass-through data and a receive loopback.
 Assumes the tester registers its transmit bit one cycle after each strobe.
*/
`timescale 1ns/1ps
module bet_framer_model
    import bet_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic flip,
    input wire logic t1_mode,
    input wire logic net_tx_out,
    input wire logic bp_tx_out,
    output bet_pkg::bet_slot_t frm_slot,
    output logic net_tx_in,
    output logic bp_tx_in,
    output logic net_rx_in,
    output logic bp_rx_in,
    output logic [15:0] nstrobe,
    output logic [15:0] nfbit
);
    logic [1:0] phase; // One strobe every four clocks.
    logic [4:0] idx; // Frame position; zero is the framing bit.
    logic seen; // High in the cycle where the tester bit stands.
    logic pend; // One inversion is owed to the next looped bit.
    // Strobes and frame position; a framing bit exists only in T1 frames.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            phase <= 2'h0;
            idx <= 5'h1;
            frm_slot <= '0;
            nstrobe <= 16'h0;
            nfbit <= 16'h0;
        end else begin
            phase <= phase + 2'h1;
            frm_slot.valid <= run && phase == 2'h3;
            if (run && phase == 2'h3) begin
                frm_slot.fbit <= idx == 5'h0;
                frm_slot.slot <= idx - 5'h1;
                idx <= (idx == 5'h18) ? {4'h0, !t1_mode} : idx + 5'h1;
                nstrobe <= nstrobe + 16'h1;
                nfbit <= nfbit + {15'h0, idx == 5'h0};
            end
        end
    end
    // Pass-through sources toggle every clock, so a stale copy shows up.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            net_tx_in <= 1'b0;
            bp_tx_in <= 1'b1;
        end else begin
            net_tx_in <= ~net_tx_in;
            bp_tx_in <= ~bp_tx_in;
        end
    end
    // Loop each transmitted bit back, inverted when the bench asks for it.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            seen <= 1'b0;
            pend <= 1'b0;
            net_rx_in <= 1'b0;
            bp_rx_in <= 1'b0;
        end else begin
            seen <= frm_slot.valid;
            if (seen) begin
                net_rx_in <= net_tx_out ^ (pend | flip);
                bp_rx_in <= bp_tx_out ^ (pend | flip);
                pend <= 1'b0;
            end else if (flip) begin
                pend <= 1'b1;
            end
        end
    end
endmodule

// *** verif/bet_top_test.sv ***
/*
 Self-checking bench for the bit error rate tester over APB.
 Assumes the framer model on the far side; narrowed counters overflow soon.
*/
`timescale 1ns/1ps
module bet_top_test;
    import bet_pkg::*;
    logic core_clk = 1'b0; // 100 MHz clock.
    logic nrst = 1'b0; // Reset, active low.
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic run = 1'b0; // Framer strobes while high.
    logic flip = 1'b0; // Asks the framer to corrupt looped bits.
    logic t1_mode = 1'b0;
    logic ce = 1'b1; // The only input held constant.
    logic [31:0] ctl_v = 32'h0; // Shadow of the control register.
    logic [31:0] prdata, rdv;
    logic pready, pslverr, erv, net_tx_out, bp_tx_out, event_alert;
    logic net_tx_in, bp_tx_in, net_rx_in, bp_rx_in;
    logic [15:0] nstrobe, nfbit;
    bet_slot_t frm_slot;
    logic b[160]; // Captured transmit bits.
    int bad_count = 0, checked = 0;
    always #5 core_clk = ~core_clk;
    bet_top #(.BCNT_W(8), .ECNT_W(4)) i_bet_top (.core_clk(core_clk), .nrst(nrst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .frm_slot(frm_slot),
        .t1_mode(t1_mode), .net_tx_in(net_tx_in), .bp_tx_in(bp_tx_in), .net_rx_in(net_rx_in),
        .bp_rx_in(bp_rx_in), .net_tx_out(net_tx_out), .bp_tx_out(bp_tx_out),
        .event_alert(event_alert));
    bet_framer_model i_bet_framer_model (.core_clk(core_clk), .nrst(nrst), .run(run),
        .flip(flip), .t1_mode(t1_mode), .net_tx_out(net_tx_out), .bp_tx_out(bp_tx_out),
        .frm_slot(frm_slot), .net_tx_in(net_tx_in), .bp_tx_in(bp_tx_in),
        .net_rx_in(net_rx_in), .bp_rx_in(bp_rx_in), .nstrobe(nstrobe), .nfbit(nfbit));
    // Compares one value and counts the outcome.
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        // Only the watchdog ends a wait for the answer.
        while (pready !== 1'b1) @(posedge core_clk);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    // Waits for a number of framer strobes.
    task automatic strobe(input int k);
        repeat (k) begin
            do @(posedge core_clk); while (frm_slot.valid !== 1'b1);
        end
    endtask
    // Polls the live sync bit; the poll is bounded.
    task automatic wait_sync(input logic want, input string nm);
        int n;
        n = 0;
        do begin
            rd(ADDR_INFO);
            n++;
        end while (rdv[0] !== want && n < 400);
        chk(nm, {31'h0, rdv[0]}, {31'h0, want});
    endtask
    // Disabling first makes the generators reseed before each new mode.
    task automatic cfg(input logic [2:0] m, input logic [4:0] len, input logic [2:0] mk);
        ctl_v = {19'h0, len, mk, ctl_v[4], m, 1'b0};
        apb(1'b1, ADDR_CTRL, ctl_v);
        ctl_v[0] = 1'b1;
        apb(1'b1, ADDR_CTRL, ctl_v);
    endtask
    // Any change of the load bit clears both counters.
    task automatic clear_counts();
        ctl_v[4] = ~ctl_v[4];
        apb(1'b1, ADDR_CTRL, ctl_v);
    endtask
    // One corrupted bit, then time for it to be checked.
    task automatic err_pulse();
        @(posedge core_clk);
        flip <= 1'b1;
        @(posedge core_clk);
        flip <= 1'b0;
        strobe(3);
        @(negedge core_clk);
    endtask
    task automatic capture();
        for (int i = 0; i < 160; i++) begin
            strobe(1);
            @(negedge core_clk);
            b[i] = net_tx_out;
        end
    endtask
    task automatic test_regs();
        logic [7:0] a[7] = '{ADDR_CTRL, ADDR_PAT, ADDR_AWC, ADDR_IFC, ADDR_TXSEL, ADDR_RXSEL, 8'h28};
        logic [31:0] e[7] = '{CTRL_RST, PAT_RST, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 7; i++) begin
            rd(a[i]);
            chk("reset value", rdv, e[i]);
            chk("slave error", {31'h0, erv}, {31'h0, i == 6});
        end
        apb(1'b1, 8'h06, 32'h1);
        chk("unaligned", {31'h0, erv}, 32'h1);
        apb(1'b1, ADDR_BCNT, 32'hFF);
        rd(ADDR_BCNT);
        chk("count read only", rdv, 32'h0);
        $display("test_regs done");
    endtask
    task automatic test_modes();
        int n, last;
        apb(1'b1, ADDR_IFC, 32'h1);
        apb(1'b1, ADDR_TXSEL, 32'h00FF_FFFF);
        apb(1'b1, ADDR_RXSEL, 32'h00FF_FFFF);
        apb(1'b1, ADDR_AWC, 32'h2);
        run <= 1'b1;
        for (int m = 0; m < 7; m++) begin
            apb(1'b1, ADDR_PAT, m == 4 ? 32'h5AD6_B5AD : m == 5 ? 32'hFFFF_0000 : PAT_RST);
            cfg(m[2:0], 5'h4, 3'h0);
            wait_sync(1'b1, "mode lock");
            if (m == 4) begin
                capture();
                n = 0;
                for (int i = 0; i < 5; i++) n += b[i];
                chk("pattern ones", n, 3);
                for (int i = 0; i < 35; i++) chk("repeat", {31'h0, b[i + 5]}, {31'h0, b[i]});
            end
            if (m == 5) begin
                capture();
                last = -1;
                n = 0;
                for (int i = 1; i < 160; i++) begin
                    if (b[i] !== b[i - 1]) begin
                        if (last >= 0) chk("word run", i - last, 32);
                        last = i;
                        n++;
                    end
                end
                chk("word flips", {31'h0, n >= 4}, 32'h1);
            end
        end
        $display("test_modes done");
    endtask
    // Counts received bits over a known number of strobes, F-bit in or out.
    task automatic test_count(input logic fus);
        logic [15:0] s0, f0;
        apb(1'b1, ADDR_IFC, 32'hD);
        apb(1'b1, ADDR_PAT, 32'h5AD6_B5AD);
        cfg(PM_REPEAT, 5'h4, 3'h0);
        wait_sync(1'b1, "count lock");
        run <= 1'b0;
        apb(1'b1, ADDR_IFC, fus ? 32'hD : 32'h1);
        clear_counts();
        rd(ADDR_BCNT);
        chk("cleared", rdv, 32'h0);
        s0 = nstrobe;
        f0 = nfbit;
        run <= 1'b1;
        strobe(40);
        run <= 1'b0;
        repeat (8) @(posedge core_clk);
        rd(ADDR_BCNT);
        chk("bit count", rdv, {16'h0, nstrobe - s0 - (fus ? 16'h0 : nfbit - f0)});
        run <= 1'b1;
        $display("test_count done");
    endtask
    task automatic test_err();
        apb(1'b1, ADDR_IFC, 32'hD);
        cfg(PM_REPEAT, 5'h4, 3'h2);
        wait_sync(1'b1, "err lock");
        clear_counts();
        rd(ADDR_SR9);
        err_pulse();
        chk("alert", {31'h0, event_alert}, 32'h1);
        rd(ADDR_ECNT);
        chk("error count", rdv, 32'h1);
        rd(ADDR_INFO);
        chk("info error", {31'h0, rdv[2]}, 32'h1);
        rd(ADDR_INFO);
        chk("info cleared", {31'h0, rdv[2]}, 32'h0);
        rd(ADDR_SR9);
        chk("status error", {31'h0, rdv[EV_ERR]}, 32'h1);
        @(negedge core_clk);
        chk("alert cleared", {31'h0, event_alert}, 32'h0);
        ctl_v[6] = 1'b0;
        apb(1'b1, ADDR_CTRL, ctl_v);
        err_pulse();
        chk("masked alert", {31'h0, event_alert}, 32'h0);
        rd(ADDR_SR9);
        chk("masked latch", {31'h0, rdv[EV_ERR]}, 32'h1);
        @(posedge core_clk);
        flip <= 1'b1;
        wait_sync(1'b0, "sync lost");
        rd(ADDR_SR9);
        chk("sync change", {31'h0, rdv[EV_SYNC]}, 32'h1);
        flip <= 1'b0;
        wait_sync(1'b1, "relock");
        $display("test_err done");
    endtask
    // Sparse errors keep the lock while both narrowed counters saturate.
    task automatic test_ovf();
        ctl_v[7] = 1'b1;
        clear_counts();
        for (int i = 0; i < 20; i++) begin
            err_pulse();
            strobe(13);
        end
        rd(ADDR_ECNT);
        chk("error saturate", rdv, 32'hF);
        rd(ADDR_BCNT);
        chk("bit saturate", rdv, 32'hFF);
        rd(ADDR_INFO);
        chk("overflow flags", {30'h0, rdv[4:3]}, 32'h3);
        @(negedge core_clk);
        chk("overflow alert", {31'h0, event_alert}, 32'h1);
        $display("test_ovf done");
    endtask
    task automatic test_dir();
        logic v;
        apb(1'b1, ADDR_IFC, 32'hF);
        cfg(PM_REPEAT, 5'h4, 3'h0);
        wait_sync(1'b1, "backplane lock");
        for (int i = 0; i < 8; i++) begin
            @(negedge core_clk);
            v = net_tx_in;
            @(negedge core_clk);
            chk("network pass", {31'h0, net_tx_out}, {31'h0, v});
        end
        $display("test_dir done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Cuts a hang short well past the expected run length.
    initial begin
        #800000;
        bad_count++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        test_regs();
        test_modes();
        t1_mode <= 1'b1;
        test_count(1'b1);
        test_count(1'b0);
        test_err();
        test_ovf();
        test_dir();
        complete_run();
    end
endmodule
